// File: dcw_host.sv
// Host end: AXI4-Lite registers drive the serial link
module dcw_host
    import dcw_pkg::*;
#(
    parameter int DIV = SCLK_DIV
)(
    input  wire logic        MCLK,
    input  wire logic        NRST,
    dcw_link_if.host         LINK,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_END} dcw_st_t;
    dcw_st_t st_q, st_d;
    logic [WORD_W-1:0] word_q, word_d, sh_q, sh_d, rx_q, rx_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [7:0]  div_q, div_d;
    logic        load_q, load_d, go_q, go_d;
    logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d, bad_q, bad_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic        sdo_l;

    dcw_sync u_sdo (.clk(MCLK), .rst_n(NRST), .din(LINK.sdout), .lvl(sdo_l), .rise(), .fall());

    assign S_AXI_AWREADY = ~aw_q & ~b_q;
    assign S_AXI_WREADY  = ~w_q & ~b_q;
    assign S_AXI_ARREADY = ~r_q;
    assign S_AXI_BVALID  = b_q;
    assign S_AXI_BRESP   = bad_q ? RESP_SLVERR : RESP_OKAY;
    assign S_AXI_RVALID  = r_q;
    assign S_AXI_RDATA   = rd_q;
    assign S_AXI_RRESP   = RESP_OKAY;

    always_comb begin
        aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q; bad_d = bad_q;
        awa_d = awa_q; wd_d = wd_q; rd_d = rd_q;
        word_d = word_q; load_d = load_q; go_d = 1'b0;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_d = 1'b1; awa_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_d = 1'b1; wd_d = S_AXI_WDATA;
        end
        if (aw_q && w_q) begin
            aw_d = 1'b0; w_d = 1'b0; b_d = 1'b1; bad_d = 1'b0;
            case (awa_q)
                REG_CTRL: begin
                    load_d = ~wd_q[1];
                    // Start requests while busy are dropped (load bit still taken); software polls busy first
                    go_d   = wd_q[0] & (st_q == ST_IDLE);
                end
                REG_WORD: word_d = wd_q[WORD_W-1:0];
                default:  bad_d = 1'b1;
            endcase
        end
        if (b_q && S_AXI_BREADY)
            b_d = 1'b0;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            r_d = 1'b1;
            case (S_AXI_ARADDR)
                REG_CTRL:   rd_d = {30'h0, ~load_q, 1'b0};
                REG_WORD:   rd_d = {14'h0, word_q};
                REG_STATUS: rd_d = {13'h0, rx_q, (st_q != ST_IDLE)};
                default:    rd_d = 32'h0;
            endcase
        end
        if (r_q && S_AXI_RREADY)
            r_d = 1'b0;
    end

    always_comb begin
        st_d = st_q; sh_d = sh_q; rx_d = rx_q; cnt_d = cnt_q; div_d = div_q;
        case (st_q)
            ST_IDLE: if (go_q) begin
                sh_d = word_q; cnt_d = 5'(WORD_W); div_d = 8'h00; st_d = ST_LOW;
            end
            ST_LOW: begin
                div_d = div_q + 8'h01;
                if (div_d == 8'(DIV/2)) begin
                    div_d = 8'h00; st_d = ST_HIGH;
                    rx_d  = {rx_q[WORD_W-2:0], sdo_l};
                end
            end
            ST_HIGH: begin
                div_d = div_q + 8'h01;
                if (div_d == 8'(DIV/2)) begin
                    div_d = 8'h00; cnt_d = cnt_q - 5'h01;
                    sh_d  = {sh_q[WORD_W-2:0], 1'b0};
                    st_d  = (cnt_q == 5'h01) ? ST_END : ST_LOW;
                end
            end
            ST_END: begin
                div_d = div_q + 8'h01;
                if (div_d == 8'(DIV/2))
                    st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0; bad_q <= 1'b0;
            awa_q <= 8'h00; wd_q <= 32'h0; rd_q <= 32'h0;
            word_q <= WORD_RESET; load_q <= 1'b1; go_q <= 1'b0;
            st_q <= ST_IDLE; sh_q <= WORD_RESET; rx_q <= 18'h0; cnt_q <= 5'h00; div_q <= 8'h00;
        end else begin
            aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d; bad_q <= bad_d;
            awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d;
            word_q <= word_d; load_q <= load_d; go_q <= go_d;
            st_q <= st_d; sh_q <= sh_d; rx_q <= rx_d; cnt_q <= cnt_d; div_q <= div_d;
        end
    end

    // Data set up while clock low; device samples on the rising clock edge
    assign LINK.cs_n   = (st_q == ST_IDLE);
    assign LINK.sclk   = (st_q == ST_HIGH);
    assign LINK.sdin   = sh_q[WORD_W-1];
    assign LINK.load_n = load_q;
endmodule

// File: dcw_pkg.sv
// Shared constants for the control word path
package dcw_pkg;
    localparam int WORD_W      = 18;
    localparam int BIT_COMMIT  = 0;
    localparam int BIT_LATCH   = 1;
    localparam int BIT_HIZCMP  = 6;
    localparam int BIT_MEASURE_HIZ_BIT_N   = 7;
    localparam int BIT_HIZFRC  = 8;
    localparam int BIT_CLAMP_ENABLE_BIT    = 10;
    localparam int BIT_FMODE   = 17;
    // High impedance, clamps off, measure output off, comparator outputs enabled
    localparam logic [17:0] WORD_RESET = 18'h00040;
    localparam int SCLK_DIV    = 16;
    localparam logic [1:0] FLOW_NOP    = 2'h0;
    localparam logic [1:0] FLOW_COMMIT = 2'h1;
    localparam logic [1:0] FLOW_LATCH  = 2'h2;
    localparam logic [1:0] FLOW_BOTH   = 2'h3;
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_WORD    = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: dcw_link_if.sv
// Serial link between host and supply
interface dcw_link_if;
    logic sclk;
    logic cs_n;
    logic sdin;
    logic sdout;
    logic load_n;
    modport host (output sclk, output cs_n, output sdin, output load_n, input sdout);
    modport dev  (input sclk, input cs_n, input sdin, input load_n, output sdout);
endinterface

// File: dcw_sync.sv
// Two-flop synchroniser with edge outputs
module dcw_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      lvl,
    output logic      rise,
    output logic      fall
);
    logic s1_q, s2_q, s3_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign lvl  = s2_q;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule

// File: dcw_dev.sv
// Supply end: shift, input and active control registers
module dcw_dev
    import dcw_pkg::*;
(
    input  wire logic              MCLK,
    input  wire logic              NRST,
    dcw_link_if.dev                LINK,
    input  wire logic              MEASURE_HIZ_PIN_N,
    input  wire logic              LEAKAGE_TEST_SELECT,
    input  wire logic              TEMP_WARN,
    input  wire logic              TEMP_SHUTDOWN,
    input  wire logic              CURRENT_ABOVE_UPPER,
    input  wire logic              CURRENT_BELOW_LOWER,
    output logic [WORD_W-1:0]      ACTIVE_WORD,
    output logic                   FORCE_HIZ,
    output logic                   FORCE_CURRENT_MODE,
    output logic                   CLAMP_ACTIVE,
    output logic                   MEASURE_OE,
    output logic                   LEAKAGE_TEST,
    output logic                   OVERTEMP_FLAG_N_O,
    output logic                   OVERTEMP_FLAG_N_OE,
    output logic                   CMP_HI_O,
    output logic                   CMP_HI_OE,
    output logic                   CMP_LO_O,
    output logic                   CMP_LO_OE
);
    logic sclk_l, sclk_r, sclk_f;
    logic cs_l, cs_r, cs_f;
    logic sdin_l, load_l, hizp_l, leak_l, warn_l, shut_l, hi_l, lo_l;
    logic [WORD_W-1:0] shift_q, shift_d, input_q, input_d, active_q, active_d;
    logic sdout_q, sdout_d, clk_seen_q, clk_seen_d;

    dcw_sync u_sclk (.clk(MCLK), .rst_n(NRST), .din(LINK.sclk), .lvl(sclk_l), .rise(sclk_r),
                     .fall(sclk_f));
    dcw_sync u_cs   (.clk(MCLK), .rst_n(NRST), .din(LINK.cs_n), .lvl(cs_l), .rise(cs_r),
                     .fall(cs_f));
    dcw_sync u_sdin (.clk(MCLK), .rst_n(NRST), .din(LINK.sdin), .lvl(sdin_l), .rise(), .fall());
    dcw_sync u_load (.clk(MCLK), .rst_n(NRST), .din(LINK.load_n), .lvl(load_l), .rise(),
                     .fall());
    dcw_sync u_hizp (.clk(MCLK), .rst_n(NRST), .din(MEASURE_HIZ_PIN_N), .lvl(hizp_l), .rise(),
                     .fall());
    dcw_sync u_leak (.clk(MCLK), .rst_n(NRST), .din(LEAKAGE_TEST_SELECT), .lvl(leak_l),
                     .rise(), .fall());
    dcw_sync u_warn (.clk(MCLK), .rst_n(NRST), .din(TEMP_WARN), .lvl(warn_l), .rise(), .fall());
    dcw_sync u_shut (.clk(MCLK), .rst_n(NRST), .din(TEMP_SHUTDOWN), .lvl(shut_l), .rise(),
                     .fall());
    dcw_sync u_hi   (.clk(MCLK), .rst_n(NRST), .din(CURRENT_ABOVE_UPPER), .lvl(hi_l), .rise(),
                     .fall());
    dcw_sync u_lo   (.clk(MCLK), .rst_n(NRST), .din(CURRENT_BELOW_LOWER), .lvl(lo_l), .rise(),
                     .fall());

    always_comb begin
        shift_d    = shift_q;
        input_d    = input_q;
        active_d   = active_q;
        sdout_d    = sdout_q;
        clk_seen_d = clk_seen_q;
        if (cs_f)
            clk_seen_d = 1'b0;
        if (!cs_l && sclk_r) begin
            shift_d    = {shift_q[WORD_W-2:0], sdin_l};
            clk_seen_d = 1'b1;
        end
        // Data out changes on the falling edge so a chained part samples it cleanly
        if (!cs_l && sclk_f)
            sdout_d = shift_q[WORD_W-1];
        if (cs_r) begin
            if (!clk_seen_q) begin
                active_d = input_q;
            end else begin
                case (shift_q[BIT_LATCH:BIT_COMMIT])
                    FLOW_NOP:    ;
                    FLOW_COMMIT: active_d = input_q;
                    FLOW_LATCH: begin
                        input_d = shift_q;
                        if (!load_l)
                            active_d = shift_q;
                    end
                    FLOW_BOTH: begin
                        input_d  = shift_q;
                        active_d = shift_q;
                    end
                    default: ;
                endcase
            end
        end
        if (!load_l && !(cs_r && clk_seen_q))
            active_d = input_q;
        if (shut_l) begin
            input_d  = WORD_RESET;
            active_d = WORD_RESET;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            shift_q    <= WORD_RESET;
            input_q    <= WORD_RESET;
            active_q   <= WORD_RESET;
            sdout_q    <= 1'b0;
            clk_seen_q <= 1'b0;
        end else begin
            shift_q    <= shift_d;
            input_q    <= input_d;
            active_q   <= active_d;
            sdout_q    <= sdout_d;
            clk_seen_q <= clk_seen_d;
        end
    end

    // Supply is steered from the active register; MEASURE_OE is also gated by its pin and LEAKAGE_TEST follows its pin alone
    assign ACTIVE_WORD        = active_q;
    assign FORCE_HIZ          = ~active_q[BIT_HIZFRC] & ~active_q[BIT_FMODE];
    assign FORCE_CURRENT_MODE = active_q[BIT_FMODE];
    assign CLAMP_ACTIVE       = active_q[BIT_CLAMP_ENABLE_BIT];
    assign MEASURE_OE         = hizp_l & active_q[BIT_MEASURE_HIZ_BIT_N];
    assign LEAKAGE_TEST       = leak_l;
    assign OVERTEMP_FLAG_N_O  = 1'b0;
    assign OVERTEMP_FLAG_N_OE = warn_l & ~shut_l;
    // Open collector: pull low when flag active, comparator gated by word bit
    assign CMP_HI_O           = 1'b0;
    assign CMP_HI_OE          = hi_l & active_q[BIT_HIZCMP];
    assign CMP_LO_O           = 1'b0;
    assign CMP_LO_OE          = lo_l & active_q[BIT_HIZCMP];
    assign LINK.sdout         = sdout_q;
endmodule

// File: dcw_props.sv
// Link checker: framing and idle behaviour of the serial wire
module dcw_props (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdin,
    input wire logic sdout,
    input wire logic load_n
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic       sclk_q;
    // Rising serial clock edges seen within the current frame
    always_comb cnt_d = cs_n ? 5'h00 : cnt_q + 5'(sclk && !sclk_q);
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cnt_q  <= 5'h00;
            sclk_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            sclk_q <= sclk;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    idle_clock_a: assert property (cs_n |-> !sclk)
        else $error("serial clock moved while deselected");
    word_length_a: assert property ($rose(cs_n) |-> cnt_q == 5'd18)
        else $error("frame did not carry eighteen bits");
    high_phase_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("serial clock high phase wrong");
    low_phase_a: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("serial clock low phase too short");
    frame_lead_a: assert property ($fell(cs_n) |-> !sclk [*8])
        else $error("clock rose too soon after select");
    data_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdin))
        else $error("data changed while clock high");
    select_hold_a: assert property ($rose(sclk) |-> !cs_n [*8])
        else $error("select released inside a bit");
    quiet_out_a: assert property (cs_n && $past(cs_n, 4) |-> $stable(sdout))
        else $error("data output moved while deselected");
    cover property ($rose(cs_n) && cnt_q == 5'd18);
    cover property ($fell(load_n));
    cover property ($rose(sdout));
endmodule

// File: tb.sv
// Bench: host and supply ends joined over the serial link
module tb;
    import dcw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 1'b0;
    logic NRST = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ld = 0;
    logic pin_n = 1, leak = 0, warn = 0, shut = 0, above = 0, below = 0;
    wire awready, wready, bvalid, arready, rvalid, hiz, clamp, moe, leak_o, ot_oe, hi_oe, lo_oe;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [WORD_W-1:0] act_w;
    wire fcm;
    logic [17:0] prev_w = WORD_RESET;
    int err_count = 0, num_checks = 0, seed = 70;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [17:0] aq[$];
    logic [17:0] in_m = WORD_RESET, act_m = WORD_RESET, last_w = WORD_RESET;
    logic [1:0] seq [8] = '{FLOW_LATCH, FLOW_COMMIT, FLOW_BOTH, FLOW_NOP,
                            FLOW_LATCH, FLOW_NOP, FLOW_COMMIT, FLOW_BOTH};
    always #2 MCLK = ~MCLK;
    dcw_link_if link ();
    dcw_host i_dcw_host (.MCLK(MCLK), .NRST(NRST), .LINK(link.host), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    dcw_dev i_dcw_dev (.MCLK(MCLK), .NRST(NRST), .LINK(link.dev), .MEASURE_HIZ_PIN_N(pin_n),
        .LEAKAGE_TEST_SELECT(leak), .TEMP_WARN(warn), .TEMP_SHUTDOWN(shut),
        .CURRENT_ABOVE_UPPER(above), .CURRENT_BELOW_LOWER(below), .ACTIVE_WORD(act_w),
        .FORCE_HIZ(hiz), .FORCE_CURRENT_MODE(fcm), .CLAMP_ACTIVE(clamp), .MEASURE_OE(moe),
        .LEAKAGE_TEST(leak_o), .OVERTEMP_FLAG_N_O(), .OVERTEMP_FLAG_N_OE(ot_oe), .CMP_HI_O(),
        .CMP_HI_OE(hi_oe), .CMP_LO_O(), .CMP_LO_OE(lo_oe));
    dcw_props i_dcw_props (.MCLK(MCLK), .NRST(NRST), .sclk(link.sclk), .cs_n(link.cs_n),
        .sdin(link.sdin), .sdout(link.sdout), .load_n(link.load_n));
    task automatic report(input logic [33:0] g, input logic [33:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
        report(g, e);
    endtask
    task automatic chk_w(input logic [17:0] g, input logic [17:0] e);
        report({16'h0, g}, {16'h0, e});
    endtask
    task automatic chk_b(input logic g, input logic e);
        report({33'h0, g}, {33'h0, e});
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tr;
        bq.push_back(r);
        @(posedge MCLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge MCLK);
            ta = awready;
            tw = wready;
            tr = bvalid;
            @(posedge MCLK);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tr);
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, input logic [33:0] e);
        logic ta, tr;
        rq.push_back(e);
        @(posedge MCLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge MCLK);
            ta = arready;
            tr = rvalid;
            @(posedge MCLK);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask
    // Notes the expected active word before the frame that changes it
    task automatic send(input logic [1:0] c);
        logic [17:0] w;
        logic [17:0] nxt;
        // Range field held fixed so no range change is ever commanded
        w = (18'($random(seed)) & 18'h3C5FC) | 18'(c);
        if (c[1]) in_m = w;
        nxt = (c[0] || ld) ? in_m : act_m;
        if (nxt !== act_m) aq.push_back(nxt);
        act_m = nxt;
        axw(REG_WORD, {14'h0, w}, RESP_OKAY);
        axw(REG_CTRL, {30'h0, ld, 1'b1}, RESP_OKAY);
        wait (link.cs_n === 1'b0);
        wait (link.cs_n === 1'b1);
        repeat (12) @(negedge MCLK);
        chk_w(act_w, act_m);
        // Data out replays the previous word one frame later
        axr(REG_STATUS, {15'h0, prev_w, 1'b0});
        prev_w = w;
    endtask
    task automatic outs();
        @(posedge MCLK);
        pin_n <= 1'($random(seed));
        leak <= 1'($random(seed));
        above <= 1'($random(seed));
        below <= 1'($random(seed));
        repeat (6) @(negedge MCLK);
        chk_b(moe, pin_n & act_m[BIT_MEASURE_HIZ_BIT_N]);
        chk_b(hi_oe, above & act_m[BIT_HIZCMP]);
        chk_b(lo_oe, below & act_m[BIT_HIZCMP]);
        chk_b(leak_o, leak);
        chk_b(clamp, act_m[BIT_CLAMP_ENABLE_BIT]);
        chk_b(hiz, ~act_m[BIT_HIZFRC] & ~act_m[BIT_FMODE]);
        chk_b(fcm, act_m[BIT_FMODE]);
    endtask
    task automatic close_out();
        chk_b(aq.size() + rq.size() + bq.size() != 0, 1'b0);
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Any change of the active word must match the oldest note
    always @(negedge MCLK) begin
        if (bvalid && bready) chk_rd({32'h0, bresp}, {32'h0, bq.pop_front()});
        if (rvalid && rready) chk_rd({rresp, rdata}, rq.pop_front());
        if (NRST && act_w !== last_w) begin
            chk_w(act_w, aq.size() ? aq.pop_front() : last_w);
            last_w = act_w;
        end
    end
    initial begin
        #200us;
        err_count++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge MCLK);
        NRST <= 1'b1;
        @(negedge MCLK);
        chk_w(act_w, WORD_RESET);
        chk_b(hiz, 1'b1);
        axr(REG_WORD, {16'h0, WORD_RESET});
        axr(8'hFC, 34'h0);
        axw(8'hFC, 32'h0, RESP_SLVERR);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            send(seq[i]);
            outs();
        end
        $display("flow test done");
        send(FLOW_LATCH);
        ld = 1'b1;
        if (in_m !== act_m) aq.push_back(in_m);
        act_m = in_m;
        axw(REG_CTRL, 32'h2, RESP_OKAY);
        repeat (10) @(negedge MCLK);
        axr(REG_CTRL, 34'h2);
        send(FLOW_LATCH);
        ld = 1'b0;
        axw(REG_CTRL, 32'h0, RESP_OKAY);
        $display("strobe test done");
        @(posedge MCLK);
        warn <= 1'b1;
        repeat (6) @(negedge MCLK);
        chk_b(ot_oe, 1'b1);
        in_m = WORD_RESET;
        if (act_m !== WORD_RESET) aq.push_back(WORD_RESET);
        act_m = WORD_RESET;
        @(posedge MCLK);
        shut <= 1'b1;
        repeat (6) @(negedge MCLK);
        chk_b(hiz, 1'b1);
        chk_b(ot_oe, 1'b0);
        @(posedge MCLK);
        shut <= 1'b0;
        warn <= 1'b0;
        send(FLOW_COMMIT);
        send(FLOW_BOTH);
        $display("thermal test done");
        close_out();
    end
endmodule
